// ### hdl/dfllc_map.svh
// register offsets, field positions, reset values and counts of the loop tuner
`ifndef DFLLC_MAP_SVH
`define DFLLC_MAP_SVH
`define DFLLC_ADDR_CTRL 4'h0
`define DFLLC_ADDR_MUL 4'h1
`define DFLLC_ADDR_VAL 4'h2
`define DFLLC_ADDR_STATUS 4'h3
`define DFLLC_ADDR_INTFLAG 4'h4
`define DFLLC_ADDR_INTEN 4'h5
`define DFLLC_CTRL_EN 0
`define DFLLC_CTRL_CLOSED 1
`define DFLLC_CTRL_STABLE 2
`define DFLLC_VAL_FINE_LSB 6
`define DFLLC_VAL_DIFF_LSB 16
`define DFLLC_ST_READY 0
`define DFLLC_ST_LOCKC 1
`define DFLLC_ST_LOCKF 2
`define DFLLC_ST_OOB 3
`define DFLLC_ST_RCS 4
`define DFLLC_IRQ_LOCKC 0
`define DFLLC_IRQ_LOCKF 1
`define DFLLC_IRQ_RCS 2
`define DFLLC_IRQ_OOB 3
`define DFLLC_CTRL_RST 3'h0
`define DFLLC_MUL_RST 16'h05B8
`define DFLLC_COARSE_RST 6'h1F
`define DFLLC_FINE_RST 10'h200
`define DFLLC_FLAGS_RST 4'h0
`define DFLLC_COARSE_TOL 16'h0020
`define DFLLC_FINE_TOL 16'h0001
`define DFLLC_MUL_MAX 65535
`define DFLLC_REF_STOP_CYCLES (2 * `DFLLC_MUL_MAX)
`define DFLLC_CLK_PERIOD_NS 40
`endif

// ### hdl/dfllc_pkg.sv
// types shared by the loop tuner modules
package dfllc_pkg;
    typedef enum logic [2:0] {ST_OFF, ST_COARSE, ST_FINE, ST_TRACK} dfllc_state_t;
    typedef logic [5:0] dfllc_coarse_t;
    typedef logic [9:0] dfllc_fine_t;
    typedef logic [15:0] dfllc_mul_t;
    typedef logic signed [15:0] dfllc_diff_t;
    typedef logic [16:0] dfllc_ratio_t;
    typedef logic [3:0] dfllc_flags_t;
endpackage

// ### hdl/dfllc_ratio_meas.sv
// counts loop clock cycles between reference edges
`timescale 1ns/1ns
`default_nettype none
module dfllc_ratio_meas (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control and reference
    input wire logic active,
    input wire logic ref_edge,
    // measurement
    output logic meas_valid,
    output dfllc_pkg::dfllc_ratio_t ratio
);
    dfllc_pkg::dfllc_ratio_t cnt_reg;
    logic seen_reg;

    always_ff @(posedge clk) begin
        if (!reset_n || !active) begin
            cnt_reg <= '0;
            seen_reg <= 1'b0;
            meas_valid <= 1'b0;
            ratio <= '0;
        end else if (ref_edge) begin
            cnt_reg <= '0;
            seen_reg <= 1'b1;
            meas_valid <= seen_reg;
            ratio <= (&cnt_reg) ? cnt_reg : cnt_reg + 17'h0_0001;
        end else begin
            cnt_reg <= (&cnt_reg) ? cnt_reg : cnt_reg + 17'h0_0001;
            meas_valid <= 1'b0;
        end
    end

    // a first partial period never reports
    a_first_period: assert property (@(posedge clk) disable iff (!reset_n)
        (ref_edge && active && !seen_reg) |=> !meas_valid)
        else $error("measurement from partial period");
endmodule
`default_nettype wire

// ### hdl/dfllc_ref_watch.sv
// flags a reference that stops or runs too slowly
`timescale 1ns/1ns
`default_nettype none
`include "dfllc_map.svh"
module dfllc_ref_watch #(
    parameter int LIMIT = `DFLLC_REF_STOP_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control and reference
    input wire logic active,
    input wire logic ref_edge,
    // status
    output logic stopped
);
    logic [17:0] cnt_reg;
    localparam logic [17:0] LAST = 18'(LIMIT - 1);

    always_ff @(posedge clk) begin
        if (!reset_n || !active || ref_edge) begin
            cnt_reg <= '0;
            stopped <= 1'b0;
        end else if (cnt_reg == LAST) begin
            stopped <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 18'h0_0001;
        end
    end

    a_stop_detect: assert property (@(posedge clk) disable iff (!reset_n)
        (active && !ref_edge && cnt_reg == LAST) |=> stopped)
        else $error("stopped reference not flagged");
    a_stop_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (ref_edge) |=> !stopped)
        else $error("stop flag held after reference edge");
endmodule
`default_nettype wire

// ### hdl/dfllc_top.sv
// closed-loop coarse and fine tuner of the frequency-locked loop
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "dfllc_map.svh"
module dfllc_top #(
    parameter int REF_STOP_CYCLES = `DFLLC_REF_STOP_CYCLES
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // reference clock, sampled
    input wire logic REF_CLK_IN,
    // register port
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // oscillator trims and interrupt
    output dfllc_pkg::dfllc_coarse_t COARSE_TRIM,
    output dfllc_pkg::dfllc_fine_t FINE_TRIM,
    output logic IRQ
);
    function automatic dfllc_pkg::dfllc_diff_t sat_diff(input logic signed [17:0] d);
        if (d > 18'sd32767) begin
            sat_diff = 16'sh7FFF;
        end else if (d < -18'sd32768) begin
            sat_diff = 16'sh8000;
        end else begin
            sat_diff = d[15:0];
        end
    endfunction

    function automatic logic [15:0] diff_mag(input dfllc_pkg::dfllc_diff_t d);
        diff_mag = d[15] ? 16'(-d) : 16'(d);
    endfunction

    // registers
    logic [2:0] ctrl_reg;
    dfllc_pkg::dfllc_mul_t mul_reg;
    dfllc_pkg::dfllc_flags_t inten_reg;
    dfllc_pkg::dfllc_flags_t flag_reg;
    dfllc_pkg::dfllc_diff_t diff_reg;
    dfllc_pkg::dfllc_state_t state;
    logic lockc_reg;
    logic lockf_reg;
    logic ready_reg;
    logic oob_reg;
    logic rcs_reg;
    logic ref_prev_reg;

    // internal nets
    logic en;
    logic active;
    logic stable;
    logic ref_edge;
    logic meas_valid;
    dfllc_pkg::dfllc_ratio_t ratio;
    logic ref_stopped;
    logic meas_ok;
    dfllc_pkg::dfllc_diff_t diff_now;
    logic coarse_hit;
    logic fine_hit;
    logic step_coarse;
    logic step_fine;
    logic oob_ev;
    logic lockc_now;
    logic lockf_now;
    dfllc_pkg::dfllc_flags_t events;
    logic val_load;

    assign en = ctrl_reg[`DFLLC_CTRL_EN];
    assign active = en && ctrl_reg[`DFLLC_CTRL_CLOSED];
    assign stable = ctrl_reg[`DFLLC_CTRL_STABLE];

    // reference edge detect
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ref_prev_reg <= 1'b0;
        end else begin
            ref_prev_reg <= REF_CLK_IN;
        end
    end
    assign ref_edge = REF_CLK_IN && !ref_prev_reg;

    dfllc_ratio_meas u_meas (
        .clk(CLK),
        .reset_n(RESET_N),
        .active(active && !ref_stopped),
        .ref_edge(ref_edge),
        .meas_valid(meas_valid),
        .ratio(ratio)
    );

    dfllc_ref_watch #(.LIMIT(REF_STOP_CYCLES)) u_watch (
        .clk(CLK),
        .reset_n(RESET_N),
        .active(active),
        .ref_edge(ref_edge),
        .stopped(ref_stopped)
    );

    // measured error and decisions
    assign diff_now = sat_diff($signed({1'b0, ratio}) - $signed({2'b00, mul_reg}));
    assign meas_ok = meas_valid && !ref_stopped && active;
    assign coarse_hit = diff_mag(diff_now) <= `DFLLC_COARSE_TOL;
    assign fine_hit = diff_mag(diff_now) <= `DFLLC_FINE_TOL;
    assign step_coarse = meas_ok && state == dfllc_pkg::ST_COARSE && !coarse_hit;
    assign step_fine = meas_ok && ((state == dfllc_pkg::ST_FINE && !fine_hit)
        || (state == dfllc_pkg::ST_TRACK && !stable && diff_now != 16'sh0000));
    assign oob_ev = step_fine && ((diff_now > 16'sh0000 && FINE_TRIM == '0)
        || (diff_now < 16'sh0000 && &FINE_TRIM));
    assign lockc_now = state == dfllc_pkg::ST_FINE || state == dfllc_pkg::ST_TRACK;
    assign lockf_now = state == dfllc_pkg::ST_TRACK;
    assign val_load = WR && ADDR == `DFLLC_ADDR_VAL && state == dfllc_pkg::ST_OFF;

    // tuning sequence
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            state <= dfllc_pkg::ST_OFF;
        end else if (!active) begin
            state <= dfllc_pkg::ST_OFF;
        end else begin
            case (state)
                dfllc_pkg::ST_OFF: begin
                    state <= dfllc_pkg::ST_COARSE;
                end
                dfllc_pkg::ST_COARSE: begin
                    if (meas_ok && coarse_hit) begin
                        state <= dfllc_pkg::ST_FINE;
                    end
                end
                dfllc_pkg::ST_FINE: begin
                    if (meas_ok && fine_hit) begin
                        state <= dfllc_pkg::ST_TRACK;
                    end
                end
                dfllc_pkg::ST_TRACK: begin
                    state <= dfllc_pkg::ST_TRACK;
                end
                default: begin
                    state <= dfllc_pkg::ST_OFF;
                end
            endcase
        end
    end

    // trim values
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            COARSE_TRIM <= `DFLLC_COARSE_RST;
            FINE_TRIM <= `DFLLC_FINE_RST;
        end else if (val_load) begin
            COARSE_TRIM <= WDATA[`DFLLC_VAL_FINE_LSB-1:0];
            FINE_TRIM <= WDATA[`DFLLC_VAL_DIFF_LSB-1:`DFLLC_VAL_FINE_LSB];
        end else begin
            if (step_coarse) begin
                if (diff_now > 16'sh0000 && COARSE_TRIM != '0) begin
                    COARSE_TRIM <= COARSE_TRIM - 6'h01;
                end else if (diff_now < 16'sh0000 && !(&COARSE_TRIM)) begin
                    COARSE_TRIM <= COARSE_TRIM + 6'h01;
                end
            end
            if (step_fine && !oob_ev) begin
                if (diff_now > 16'sh0000) begin
                    FINE_TRIM <= FINE_TRIM - 10'h001;
                end else begin
                    FINE_TRIM <= FINE_TRIM + 10'h001;
                end
            end
        end
    end

    // status levels
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            lockc_reg <= 1'b0;
            lockf_reg <= 1'b0;
            ready_reg <= 1'b0;
            rcs_reg <= 1'b0;
        end else begin
            lockc_reg <= lockc_now && active;
            lockf_reg <= lockf_now && active;
            ready_reg <= en;
            rcs_reg <= ref_stopped;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N || !active) begin
            oob_reg <= 1'b0;
        end else if (oob_ev) begin
            oob_reg <= 1'b1;
        end
    end

    assign events[`DFLLC_IRQ_LOCKC] = lockc_now && !lockc_reg;
    assign events[`DFLLC_IRQ_LOCKF] = lockf_now && !lockf_reg;
    assign events[`DFLLC_IRQ_RCS] = ref_stopped && !rcs_reg;
    assign events[`DFLLC_IRQ_OOB] = oob_ev;

    // sticky event flags, set wins over write-one clear
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            flag_reg <= `DFLLC_FLAGS_RST;
        end else if (WR && ADDR == `DFLLC_ADDR_INTFLAG) begin
            flag_reg <= (flag_reg & ~WDATA[3:0]) | events;
        end else begin
            flag_reg <= flag_reg | events;
        end
    end
    assign IRQ = |(flag_reg & inten_reg);

    // stored ratio difference
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            diff_reg <= '0;
        end else if (meas_ok) begin
            diff_reg <= diff_now;
        end
    end

    // writable registers
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ctrl_reg <= `DFLLC_CTRL_RST;
            mul_reg <= `DFLLC_MUL_RST;
            inten_reg <= `DFLLC_FLAGS_RST;
        end else if (WR) begin
            case (ADDR)
                `DFLLC_ADDR_CTRL: ctrl_reg <= WDATA[2:0];
                `DFLLC_ADDR_MUL: mul_reg <= WDATA[15:0];
                `DFLLC_ADDR_INTEN: inten_reg <= WDATA[3:0];
                default: begin
                end
            endcase
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge CLK) begin
        if (!RESET_N || !RD) begin
            RDATA <= 32'h0000_0000;
        end else begin
            case (ADDR)
                `DFLLC_ADDR_CTRL: RDATA <= {29'h0000_0000, ctrl_reg};
                `DFLLC_ADDR_MUL: RDATA <= {16'h0000, mul_reg};
                `DFLLC_ADDR_VAL: RDATA <= {diff_reg, FINE_TRIM, COARSE_TRIM};
                `DFLLC_ADDR_STATUS: RDATA <= {27'h000_0000, rcs_reg, oob_reg,
                    lockf_reg, lockc_reg, ready_reg};
                `DFLLC_ADDR_INTFLAG: RDATA <= {28'h000_0000, flag_reg};
                `DFLLC_ADDR_INTEN: RDATA <= {28'h000_0000, inten_reg};
                default: RDATA <= 32'h0000_0000;
            endcase
        end
    end

    // checks
    a_coarse_lock: assert property (@(posedge CLK) disable iff (!RESET_N)
        (state == dfllc_pkg::ST_COARSE && meas_ok && coarse_hit) |-> ##2 lockc_reg)
        else $error("coarse lock not flagged");
    a_fine_lock: assert property (@(posedge CLK) disable iff (!RESET_N)
        (state == dfllc_pkg::ST_FINE && meas_ok && fine_hit) |-> ##2 lockf_reg)
        else $error("fine lock not flagged");
    a_lock_irq: assert property (@(posedge CLK) disable iff (!RESET_N)
        (lockc_now && !lockc_reg && inten_reg[`DFLLC_IRQ_LOCKC]) |=> IRQ)
        else $error("coarse lock interrupt missing");
    a_ready_lock: assert property (@(posedge CLK) disable iff (!RESET_N)
        (lockf_reg || lockc_reg) |-> ready_reg)
        else $error("lock without ready");
    a_diff_store: assert property (@(posedge CLK) disable iff (!RESET_N)
        meas_ok |=> diff_reg == $past(diff_now))
        else $error("ratio difference not stored");
    a_track_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
        (state == dfllc_pkg::ST_TRACK && active) |=> state == dfllc_pkg::ST_TRACK)
        else $error("lock dropped while tracking");
    a_oob_flag: assert property (@(posedge CLK) disable iff (!RESET_N)
        (oob_ev && active) |=> oob_reg && flag_reg[`DFLLC_IRQ_OOB])
        else $error("fine overflow not flagged");
    a_stop_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
        (ref_stopped && state != dfllc_pkg::ST_OFF) |=> $stable(FINE_TRIM)
        && $stable(COARSE_TRIM))
        else $error("trim moved while reference stopped");
    a_rcs_irq: assert property (@(posedge CLK) disable iff (!RESET_N)
        (ref_stopped && !rcs_reg && inten_reg[`DFLLC_IRQ_RCS]) |=> IRQ)
        else $error("reference stop interrupt missing");
    a_lock_clear: assert property (@(posedge CLK) disable iff (!RESET_N)
        !active |-> ##2 (!lockc_reg && !lockf_reg))
        else $error("lock held after leaving closed loop");

    // interrupt, status and tuning step checks
    a_fine_irq: assert property (@(posedge CLK) disable iff (!RESET_N)
        (lockf_now && !lockf_reg && inten_reg[`DFLLC_IRQ_LOCKF]) |=> IRQ)
        else $error("fine lock interrupt missing");
    a_lock_event: assert property (@(posedge CLK) disable iff (!RESET_N)
        (lockc_now && !lockc_reg) |=> flag_reg[`DFLLC_IRQ_LOCKC])
        else $error("coarse lock event not latched");
    a_ready_follow: assert property (@(posedge CLK) disable iff (!RESET_N)
        en |=> ready_reg)
        else $error("ready missing while enabled");
    a_coarse_up: assert property (@(posedge CLK) disable iff (!RESET_N)
        (step_coarse && diff_now < 16'sh0000 && !(&COARSE_TRIM))
        |=> COARSE_TRIM == $past(COARSE_TRIM) + 6'h01)
        else $error("coarse trim not raised");
    a_coarse_down: assert property (@(posedge CLK) disable iff (!RESET_N)
        (step_coarse && diff_now > 16'sh0000 && COARSE_TRIM != '0)
        |=> COARSE_TRIM == $past(COARSE_TRIM) - 6'h01)
        else $error("coarse trim not lowered");
    a_fine_up: assert property (@(posedge CLK) disable iff (!RESET_N)
        (step_fine && !oob_ev && diff_now < 16'sh0000)
        |=> FINE_TRIM == $past(FINE_TRIM) + 10'h001)
        else $error("fine trim not raised");
    a_fine_down: assert property (@(posedge CLK) disable iff (!RESET_N)
        (step_fine && !oob_ev && diff_now > 16'sh0000)
        |=> FINE_TRIM == $past(FINE_TRIM) - 10'h001)
        else $error("fine trim not lowered");
    a_stable_freeze: assert property (@(posedge CLK) disable iff (!RESET_N)
        (state == dfllc_pkg::ST_TRACK && stable) |=> $stable(FINE_TRIM))
        else $error("fine trim moved with stable set");
    a_oob_saturate: assert property (@(posedge CLK) disable iff (!RESET_N)
        oob_ev |=> $stable(FINE_TRIM))
        else $error("fine trim wrapped");
    a_oob_inactive: assert property (@(posedge CLK) disable iff (!RESET_N)
        !active |=> !oob_reg)
        else $error("out of bounds held while inactive");
    a_rcs_status: assert property (@(posedge CLK) disable iff (!RESET_N)
        ref_stopped |=> rcs_reg)
        else $error("stopped status missing");
    a_rcs_event: assert property (@(posedge CLK) disable iff (!RESET_N)
        (ref_stopped && !rcs_reg) |=> flag_reg[`DFLLC_IRQ_RCS])
        else $error("reference stop event not latched");
    a_diff_frozen: assert property (@(posedge CLK) disable iff (!RESET_N)
        ref_stopped |=> $stable(diff_reg))
        else $error("ratio difference moved while reference stopped");
endmodule
`default_nettype wire

// ### verification/dfllc_ref_src.sv
// reference oscillator model sampled on the loop clock
`timescale 1ns/1ns
`default_nettype none
module dfllc_ref_src (
    // clock
    input wire logic clk,
    // control
    input wire logic run,
    input wire logic follow,
    input wire logic [15:0] base,
    // loop trims
    input wire dfllc_pkg::dfllc_coarse_t coarse,
    input wire dfllc_pkg::dfllc_fine_t fine,
    // reference out
    output logic ref_clk
);
    int cnt = 0;
    int nxt;
    int per;
    initial ref_clk = 1'h0;
    // period tracks the trims so the loop can close
    always_comb begin
        per = follow ? int'(base) + int'(coarse) + int'(fine) - 543 : int'(base);
        nxt = (cnt + 1 >= per) ? 0 : cnt + 1;
    end
    // steady period, holds its level while halted
    always @(posedge clk) begin
        if (run) begin
            cnt <= nxt;
            ref_clk <= (nxt < per / 2);
        end
    end
endmodule
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the loop tuner
`timescale 1ns/1ns
`default_nettype none
`include "dfllc_map.svh"
module testbench;
    logic CLK = 1'h0;
    logic RESET_N = 1'h0;
    logic REF_CLK_IN;
    logic [3:0] ADDR = 4'h0;
    logic [31:0] WDATA = 32'h0000_0000;
    logic WR = 1'h0;
    logic RD = 1'h0;
    logic [31:0] RDATA;
    dfllc_pkg::dfllc_coarse_t COARSE_TRIM;
    dfllc_pkg::dfllc_fine_t FINE_TRIM;
    logic IRQ;
    logic run = 1'h1;
    logic follow = 1'h1;
    logic [15:0] base = 16'h000A;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] d;
    dfllc_pkg::dfllc_fine_t f0;

    dfllc_top #(.REF_STOP_CYCLES(64)) dut (.CLK(CLK), .RESET_N(RESET_N),
        .REF_CLK_IN(REF_CLK_IN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .COARSE_TRIM(COARSE_TRIM), .FINE_TRIM(FINE_TRIM), .IRQ(IRQ));
    dfllc_ref_src ref_src (.clk(CLK), .run(run), .follow(follow), .base(base),
        .coarse(COARSE_TRIM), .fine(FINE_TRIM), .ref_clk(REF_CLK_IN));

    always #20 CLK = ~CLK;

    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'h1;
        @(posedge CLK);
        WR <= 1'h0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'h1;
        @(posedge CLK);
        RD <= 1'h0;
        @(posedge CLK);
        v = RDATA;
    endtask

    // read until the masked value matches, bounded
    task automatic poll(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v);
        logic [31:0] r;
        int n;
        n = 0;
        r = ~v;
        while (((r & m) !== v) && n < 1000) begin
            rd(a, r);
            n++;
        end
        chk(r & m, v);
    endtask

    task automatic t_reset();
        logic [31:0] rv [7] = '{32'h0000_0000, 32'h0000_05B8, 32'h0000_801F,
            32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
        for (int i = 0; i < 7; i++) begin
            rd(4'(i), d);
            chk(d, rv[i]);
        end
        #1 chk(RDATA, 32'h0000_0000);
        chk({IRQ, COARSE_TRIM, FINE_TRIM}, 32'h0000_7E00);
    endtask

    task automatic t_lock();
        wr(`DFLLC_ADDR_MUL, 32'h0000_0032);
        wr(`DFLLC_ADDR_INTEN, 32'h0000_0002);
        wr(`DFLLC_ADDR_CTRL, 32'h0000_0003);
        poll(`DFLLC_ADDR_STATUS, 32'h0000_0007, 32'h0000_0003);
        chk(32'(COARSE_TRIM > 6'h1F), 32'h0000_0001);
        rd(`DFLLC_ADDR_INTFLAG, d);
        chk(d, 32'h0000_0001);
        #1 chk(32'(IRQ), 32'h0000_0000);
        wr(`DFLLC_ADDR_INTEN, 32'h0000_0003);
        chk(32'(IRQ), 32'h0000_0001);
        wr(`DFLLC_ADDR_INTFLAG, 32'h0000_0001);
        chk(32'(IRQ), 32'h0000_0000);
        poll(`DFLLC_ADDR_STATUS, 32'h0000_0007, 32'h0000_0007);
        rd(`DFLLC_ADDR_INTFLAG, d);
        chk(d, 32'h0000_0002);
        #1 chk(32'(IRQ), 32'h0000_0001);
        poll(`DFLLC_ADDR_VAL, 32'hFFFF_0000, 32'h0000_0000);
        wr(`DFLLC_ADDR_INTFLAG, 32'h0000_0002);
    endtask

    task automatic t_drift();
        wr(`DFLLC_ADDR_CTRL, 32'h0000_0007);
        f0 = FINE_TRIM;
        @(posedge CLK);
        base <= base + 16'h0004;
        poll(`DFLLC_ADDR_VAL, 32'hFFFF_0000, 32'h0004_0000);
        chk(32'(FINE_TRIM), 32'(f0));
        wr(`DFLLC_ADDR_CTRL, 32'h0000_0003);
        poll(`DFLLC_ADDR_VAL, 32'hFFFF_0000, 32'h0000_0000);
        chk(32'(FINE_TRIM), 32'(f0 - 10'h004));
        rd(`DFLLC_ADDR_STATUS, d);
        chk(d & 32'h0000_0007, 32'h0000_0007);
    endtask

    task automatic t_stop();
        wr(`DFLLC_ADDR_INTEN, 32'h0000_0004);
        @(posedge CLK);
        run <= 1'h0;
        rd(`DFLLC_ADDR_STATUS, d);
        chk(d & 32'h0000_0010, 32'h0000_0000);
        poll(`DFLLC_ADDR_STATUS, 32'h0000_0010, 32'h0000_0010);
        rd(`DFLLC_ADDR_INTFLAG, d);
        chk(d & 32'h0000_0004, 32'h0000_0004);
        #1 chk(32'(IRQ), 32'h0000_0001);
        f0 = FINE_TRIM;
        @(posedge CLK);
        base <= base - 16'h0002;
        repeat (100) @(posedge CLK);
        chk(32'(FINE_TRIM), 32'(f0));
        run <= 1'h1;
        poll(`DFLLC_ADDR_STATUS, 32'h0000_0010, 32'h0000_0000);
        poll(`DFLLC_ADDR_VAL, 32'hFFFF_0000, 32'hFFFE_0000);
        poll(`DFLLC_ADDR_VAL, 32'hFFFF_0000, 32'h0000_0000);
        chk(32'(FINE_TRIM), 32'(f0 + 10'h002));
        wr(`DFLLC_ADDR_INTFLAG, 32'h0000_0004);
        chk(32'(IRQ), 32'h0000_0000);
    endtask

    task automatic t_oob();
        wr(`DFLLC_ADDR_CTRL, 32'h0000_0000);
        poll(`DFLLC_ADDR_STATUS, 32'h0000_0007, 32'h0000_0000);
        @(posedge CLK);
        follow <= 1'h0;
        base <= 16'h0030;
        wr(`DFLLC_ADDR_VAL, 32'h0000_FFDF);
        chk(32'(FINE_TRIM), 32'h0000_03FF);
        wr(`DFLLC_ADDR_INTEN, 32'h0000_0008);
        wr(`DFLLC_ADDR_CTRL, 32'h0000_0003);
        poll(`DFLLC_ADDR_STATUS, 32'h0000_000A, 32'h0000_000A);
        chk(32'(FINE_TRIM), 32'h0000_03FF);
        rd(`DFLLC_ADDR_INTFLAG, d);
        chk(d & 32'h0000_0008, 32'h0000_0008);
        #1 chk(32'(IRQ), 32'h0000_0001);
    endtask

    initial begin
        repeat (5) @(posedge CLK);
        RESET_N <= 1'h1;
        t_reset();
        t_lock();
        t_drift();
        t_stop();
        t_oob();
        stop_test();
    end
endmodule
`default_nettype wire
